// >>> shared/ecpm_pkg.sv
package ecpm_pkg;
  // Register byte addresses on the plain register port
  localparam logic [10:0] ADDR_DATA   = 11'h000; // Data latch, address/RLE entry in ECP
  localparam logic [10:0] ADDR_STATUS = 11'h001; // Peripheral status lines
  localparam logic [10:0] ADDR_CTRL   = 11'h002; // Control lines and direction
  localparam logic [10:0] ADDR_FIFO   = 11'h400; // Queue port, capability A in config mode
  localparam logic [10:0] ADDR_CAPB   = 11'h401; // Capability B in config mode
  localparam logic [10:0] ADDR_ECR    = 11'h402; // Extended port control
  localparam logic [10:0] ADDR_LEVEL  = 11'h403; // Queue level setting and EPP option
  // Extended control field positions
  localparam int ECR_MODE_HI   = 7;
  localparam int ECR_MODE_LO   = 5;
  localparam int ECR_FAULT_DIS = 4;
  localparam int ECR_DMA_EN    = 3;
  localparam int ECR_SVC       = 2;
  localparam int ECR_FULL      = 1;
  localparam int ECR_EMPTY     = 0;
  // Control register field positions
  localparam int CTL_STROBE    = 0;
  localparam int CTL_AUTOFD    = 1;
  localparam int CTL_INIT      = 2;
  localparam int CTL_SELIN     = 3;
  localparam int CTL_ACKINT    = 4;
  localparam int CTL_DIR       = 5;
  // Level register field positions
  localparam int LVL_HI        = 3;
  localparam int LVL_EPP       = 4;
  // Reset values
  localparam logic       SVC_RESET  = 1'b1;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [7:0] CAPA_VALUE = 8'h10; // Byte-wide implementation
  // Queue shape
  localparam int         FIFO_AW    = 4;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] LEVEL_ONE  = 5'h01;
  // Port modes
  typedef enum logic [2:0] {
    MODE_SPP    = 3'b000,
    MODE_PS2    = 3'b001,
    MODE_FIFO   = 3'b010,
    MODE_ECP    = 3'b011,
    MODE_EPP    = 3'b100,
    MODE_RSVD   = 3'b101,
    MODE_TEST   = 3'b110,
    MODE_CONFIG = 3'b111
  } ecpm_mode_type;
  // Compatibility strobe width
  localparam int CLK_MHZ    = 250;
  localparam int STROBE_NS  = 500;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
endpackage

// >>> logic/ecpm_fifo.sv
`timescale 1ns/100ps
module ecpm_fifo
  import ecpm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       flush,
  // Write side, bit 8 tags a command byte
  input  wire logic       push,
  input  wire logic [8:0] pushData,
  // Read side
  input  wire logic       pop,
  output logic      [8:0] headData,
  // Fill state
  output logic            full,
  output logic            empty,
  output logic      [4:0] count
);
  logic [8:0]         mem [0:(1 << FIFO_AW) - 1]; // Byte store
  logic [FIFO_AW-1:0] wrPtr_r;                    // Next slot to fill
  logic [FIFO_AW-1:0] rdPtr_r;                    // Head slot
  logic [4:0]         count_r;                    // Bytes held
  logic               doPush;
  logic               doPop;

  // Full push and empty pop are dropped, nothing stalls
  assign doPush   = push & ~full;
  assign doPop    = pop & ~empty;
  assign full     = (count_r == FIFO_DEPTH);
  assign empty    = (count_r == 5'h00);
  assign count    = count_r;
  assign headData = mem[rdPtr_r];

  // Storage
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= pushData;
    end
  end

  // Pointers and fill count, flush empties at once
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= 5'h00;
    end else begin
      if (doPush) wrPtr_r <= wrPtr_r + 1'b1;
      if (doPop) rdPtr_r <= rdPtr_r + 1'b1;
      if (doPush && !doPop) count_r <= count_r + 5'h01;
      else if (doPop && !doPush) count_r <= count_r - 5'h01;
    end
  end
endmodule

// >>> logic/ecpm_link.sv
`timescale 1ns/100ps
module ecpm_link
  import ecpm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Run selects from the mode logic
  input  wire logic       fwdRun,
  input  wire logic       compat,
  input  wire logic       revRun,
  // Queue head and fill
  input  wire logic [8:0] headData,
  input  wire logic       headValid,
  input  wire logic       queueFull,
  // Peripheral lines
  input  wire logic       busyIn,
  input  wire logic       ackInN,
  input  wire logic [7:0] pdIn,
  // Host lines and queue strobes
  output logic      [7:0] pdOut,
  output logic            strobeN,
  output logic            autoFdN,
  output logic            popPulse,
  output logic            pushPulse,
  output logic      [7:0] pushData
);
  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_FSET = 3'b001,
    LK_FSTB = 3'b010,
    LK_FREL = 3'b011,
    LK_RWAIT = 3'b100,
    LK_RACK = 3'b101
  } ecpm_link_type;
  ecpm_link_type state_r;     // Handshake phase
  logic [7:0]    strobeCnt_r; // Compatibility strobe timer
  logic          cmdByte_r;   // Received byte was a command

  // One handshake engine; leaving the mode drops every line at once
  always_ff @(posedge clk) begin
    if (srst || !(fwdRun || revRun)) begin
      state_r     <= LK_IDLE;
      strobeN     <= 1'b1;
      autoFdN     <= 1'b1;
      popPulse    <= 1'b0;
      pushPulse   <= 1'b0;
      pdOut       <= BYTE_ZERO;
      pushData    <= BYTE_ZERO;
      strobeCnt_r <= 8'h00;
      cmdByte_r   <= 1'b0;
    end else begin
      popPulse  <= 1'b0;
      pushPulse <= 1'b0;
      case (state_r)
        // Start forward send or reverse wait
        LK_IDLE: begin
          if (fwdRun && headValid && !popPulse) begin
            pdOut   <= headData[7:0];
            autoFdN <= compat | ~headData[8];
            state_r <= LK_FSET;
          end else if (revRun) begin
            autoFdN <= 1'b0;
            state_r <= LK_RWAIT;
          end
        end
        // Data set up, compatibility waits for not busy
        LK_FSET: if (!compat || !busyIn) begin
          strobeN     <= 1'b0;
          strobeCnt_r <= 8'(STROBE_CYC);
          state_r     <= LK_FSTB;
        end
        // Strobe low until timer or peripheral busy
        LK_FSTB: begin
          if (strobeCnt_r != 8'h00) strobeCnt_r <= strobeCnt_r - 8'h01;
          if (compat ? (strobeCnt_r == 8'h00) : busyIn) begin
            strobeN <= 1'b1;
            state_r <= LK_FREL;
          end
        end
        // Peripheral released in ECP, no wait in compatibility; byte leaves the queue
        LK_FREL: if (compat || !busyIn) begin
          popPulse <= 1'b1;
          autoFdN  <= 1'b1;
          state_r  <= LK_IDLE;
        end
        // Ready for a byte while room remains
        LK_RWAIT: if (!ackInN && !queueFull) begin
          pushData  <= pdIn;
          cmdByte_r <= ~busyIn;
          autoFdN   <= 1'b1;
          state_r   <= LK_RACK;
        end
        // Peripheral clock back high, keep data bytes only
        LK_RACK: if (ackInN) begin
          pushPulse <= ~cmdByte_r;
          autoFdN   <= 1'b0;
          state_r   <= LK_RWAIT;
        end
        default: state_r <= LK_IDLE;
      endcase
    end
  end
endmodule

// >>> logic/ecpm_port_mode_control.sv
`timescale 1ns/100ps
module ecpm_port_mode_control
  import ecpm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [10:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  // DMA channel
  input  wire logic        dmaAck,
  input  wire logic        dmaTc,
  output logic             dmaReq,
  // Interrupt pulses
  output logic             faultIrq,
  output logic             serviceIrq,
  // Peripheral inputs
  input  wire logic        faultN,
  input  wire logic        busyIn,
  input  wire logic        ackInN,
  input  wire logic        selectIn,
  input  wire logic        paperErr,
  // Data lines
  input  wire logic [7:0]  pdIn,
  output logic      [7:0]  pdOut,
  output logic             pdOe,
  // Control lines: strobe, autofeed, init, select-in
  output logic      [3:0]  ctlOutN,
  output logic      [3:0]  ctlOe,
  // EPP mode active
  output logic             eppActive
);
  // Control state
  ecpm_mode_type mode_r;      // Port mode
  logic          faultDis_r;  // Fault interrupt disable
  logic          dma_transfer_enable_r;     // DMA enable
  logic          svc_r;       // Service interrupt mask
  logic          svc_nxt;
  logic [7:0]    dataReg_r;   // Data latch
  logic [5:0]    ctl_r;       // Control bits and direction
  logic [3:0]    level_r;     // Queue level setting
  logic          eppOpt_r;    // EPP option
  logic          faultPrev_r; // Fault line one cycle back
  logic [7:0]    rdNxt;
  logic [3:0]    ctlVal;
  // Queue and link wiring
  logic          qPush, qPop, qFull, qEmpty, swPush, swPop;
  logic [8:0]    qPushData, qHead;
  logic [4:0]    qCount, threshold;
  logic          linkPop, linkPush, linkStrobeN, linkAutoFdN;
  logic [7:0]    linkPd, linkPushData;
  logic          fwdRun, revRun, svcCond, faultEv, dir;
  // Access decode
  logic          wrEcr, wrCtl, wrData, wrLevel, fifoSel;

  // Mode allowed from the present one
  function automatic logic legalSwitch(input ecpm_mode_type cur, input ecpm_mode_type nxt);
    legalSwitch = (cur == MODE_SPP) || (cur == MODE_PS2) ||
                  (nxt == MODE_SPP) || (nxt == MODE_PS2);
  endfunction

  // Modes that move bytes through the queue
  function automatic logic queueMode(input ecpm_mode_type m);
    queueMode = (m == MODE_FIFO) || (m == MODE_ECP) || (m == MODE_TEST);
  endfunction

  assign dir     = ctl_r[CTL_DIR];
  assign wrEcr   = regWrEn && (regAddr == ADDR_ECR);
  assign wrCtl   = regWrEn && (regAddr == ADDR_CTRL);
  assign wrData  = regWrEn && (regAddr == ADDR_DATA);
  assign wrLevel = regWrEn && (regAddr == ADDR_LEVEL);
  assign fifoSel = dmaAck || ((regAddr == ADDR_FIFO) && (mode_r != MODE_CONFIG));

  // Link runs in 010 forward and in ECP either way
  assign fwdRun = (mode_r == MODE_FIFO && !dir) || (mode_r == MODE_ECP && !dir);
  assign revRun = (mode_r == MODE_ECP) && dir;

  // Software and DMA into the queue; address/RLE only forward
  assign swPush = regWrEn && ((fifoSel && (mode_r == MODE_FIFO || mode_r == MODE_TEST
                  || (mode_r == MODE_ECP && !dir)))
                  || (regAddr == ADDR_DATA && mode_r == MODE_ECP && !dir));
  assign swPop  = regRdEn && fifoSel && (revRun || mode_r == MODE_TEST);
  assign qPush  = swPush || linkPush;
  assign qPop   = swPop || linkPop;
  // Bit 8 tags an address/RLE byte written at the data address
  assign qPushData = linkPush ? {1'b0, linkPushData}
                   : {(regAddr == ADDR_DATA) && !dmaAck, regWrData};

  // Queue held empty in 000 and 001; reverse handshake waits while the queue is full
  ecpm_fifo u_fifo (
    .clk      (clk),
    .srst     (srst),
    .flush    ((mode_r == MODE_SPP) || (mode_r == MODE_PS2)),
    .push     (qPush),
    .pushData (qPushData),
    .pop      (qPop),
    .headData (qHead),
    .full     (qFull),
    .empty    (qEmpty),
    .count    (qCount)
  );

  // Automatic handshake engine
  ecpm_link u_link (
    .clk       (clk),
    .srst      (srst),
    .fwdRun    (fwdRun),
    .compat    (mode_r == MODE_FIFO),
    .revRun    (revRun),
    .headData  (qHead),
    .headValid (!qEmpty),
    .queueFull (qFull),
    .busyIn    (busyIn),
    .ackInN    (ackInN),
    .pdIn      (pdIn),
    .pdOut     (linkPd),
    .strobeN   (linkStrobeN),
    .autoFdN   (linkAutoFdN),
    .popPulse  (linkPop),
    .pushPulse (linkPush),
    .pushData  (linkPushData)
  );

  // Effective threshold is setting plus one
  assign threshold = {1'b0, level_r} + LEVEL_ONE;

  // Service condition for the three cases, only in queue modes
  always_comb begin
    svcCond = 1'b0;
    if (queueMode(mode_r)) begin
      if (dma_transfer_enable_r) svcCond = dmaTc;
      else if (!dir) svcCond = (FIFO_DEPTH - qCount) >= threshold;
      else svcCond = qCount >= (FIFO_DEPTH - threshold);
    end
  end

  // Set wins over a software clear; writing 1 only masks
  assign svc_nxt = svcCond || (wrEcr ? regWrData[ECR_SVC] : svc_r);

  // Fault edge, or disable cleared while fault is low
  assign faultEv = (mode_r == MODE_ECP) && !faultN &&
                   ((!faultDis_r && faultPrev_r) ||
                    (wrEcr && faultDis_r && !regWrData[ECR_FAULT_DIS]));

  // Mode field, legal switches only
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r <= MODE_SPP;
    end else if (wrEcr && legalSwitch(mode_r,
                 ecpm_mode_type'(regWrData[ECR_MODE_HI:ECR_MODE_LO]))) begin
      mode_r <= ecpm_mode_type'(regWrData[ECR_MODE_HI:ECR_MODE_LO]);
    end
  end

  // Extended control enables
  always_ff @(posedge clk) begin
    if (srst) begin
      faultDis_r <= 1'b0;
      dma_transfer_enable_r    <= 1'b0;
      svc_r      <= SVC_RESET;
    end else begin
      svc_r <= svc_nxt;
      if (wrEcr) begin
        faultDis_r <= regWrData[ECR_FAULT_DIS];
        dma_transfer_enable_r    <= regWrData[ECR_DMA_EN];
      end
    end
  end

  // Data latch and control bits; direction moves only in 001
  always_ff @(posedge clk) begin
    if (srst) begin
      dataReg_r <= BYTE_ZERO;
      ctl_r     <= 6'h00;
    end else begin
      if (wrData && mode_r != MODE_ECP) dataReg_r <= regWrData;
      if (wrCtl) begin
        ctl_r[CTL_ACKINT:CTL_STROBE] <= regWrData[CTL_ACKINT:CTL_STROBE];
        if (mode_r == MODE_PS2) ctl_r[CTL_DIR] <= regWrData[CTL_DIR];
      end
    end
  end

  // Queue level and EPP option
  always_ff @(posedge clk) begin
    if (srst) begin
      level_r  <= 4'h0;
      eppOpt_r <= 1'b0;
    end else if (wrLevel) begin
      level_r  <= regWrData[LVL_HI:0];
      eppOpt_r <= regWrData[LVL_EPP];
    end
  end

  // Interrupt pulses and DMA request
  always_ff @(posedge clk) begin
    if (srst) begin
      faultPrev_r <= 1'b1;
      faultIrq    <= 1'b0;
      serviceIrq  <= 1'b0;
      dmaReq      <= 1'b0;
      eppActive   <= 1'b0;
    end else begin
      faultPrev_r <= faultN;
      faultIrq    <= faultEv;
      serviceIrq  <= svcCond && !svc_r;
      dmaReq      <= dma_transfer_enable_r && !svc_r && queueMode(mode_r) &&
                     (dir ? !qEmpty : !qFull);
      eppActive   <= (mode_r == MODE_EPP) && eppOpt_r;
    end
  end

  // Read mux
  always_comb begin
    rdNxt = BYTE_ZERO;
    case (regAddr)
      ADDR_DATA:   rdNxt = (mode_r == MODE_PS2) ? pdIn : dataReg_r;
      ADDR_STATUS: rdNxt = {~busyIn, ackInN, paperErr, selectIn, faultN, 3'b000};
      ADDR_CTRL:   rdNxt = {2'b00, ctl_r};
      ADDR_FIFO:   rdNxt = (mode_r == MODE_CONFIG) ? CAPA_VALUE : qHead[7:0];
      ADDR_CAPB:   rdNxt = (mode_r == MODE_CONFIG) ? {1'b0, faultIrq | serviceIrq, 6'h00}
                                                   : BYTE_ZERO;
      ADDR_ECR:    rdNxt = {mode_r, faultDis_r, dma_transfer_enable_r, svc_r, qFull, qEmpty};
      ADDR_LEVEL:  rdNxt = {3'b000, eppOpt_r, level_r};
      default:     rdNxt = BYTE_ZERO;
    endcase
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (srst) regRdData <= BYTE_ZERO;
    else regRdData <= regRdEn ? (dmaAck ? qHead[7:0] : rdNxt) : BYTE_ZERO;
  end

  // Control line levels: link owns strobe and autofeed in 010 forward and in 011
  always_comb begin
    ctlVal[0] = (fwdRun || revRun) ? linkStrobeN : ~ctl_r[CTL_STROBE];
    ctlVal[1] = (fwdRun || revRun) ? linkAutoFdN : ~ctl_r[CTL_AUTOFD];
    ctlVal[2] = ctl_r[CTL_INIT];
    ctlVal[3] = ~ctl_r[CTL_SELIN];
  end

  // Data lines; direction ignored in 000
  always_ff @(posedge clk) begin
    if (srst) begin
      pdOut <= BYTE_ZERO;
      pdOe  <= 1'b1;
    end else begin
      pdOut <= fwdRun ? linkPd : dataReg_r;
      pdOe  <= !((mode_r == MODE_PS2 || mode_r == MODE_ECP) && dir);
    end
  end

  // Control drivers: open-collector in 000, push-pull otherwise
  for (genvar i = 0; i < 4; i++) begin : g_ctl
    always_ff @(posedge clk) begin
      if (srst) begin
        ctlOutN[i] <= 1'b1;
        ctlOe[i]   <= 1'b0;
      end else begin
        ctlOutN[i] <= ctlVal[i];
        ctlOe[i]   <= (mode_r == MODE_SPP) ? !ctlVal[i] : 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_mode_hold: assert property (wrEcr && !legalSwitch(mode_r,
      ecpm_mode_type'(regWrData[ECR_MODE_HI:ECR_MODE_LO])) |=> $stable(mode_r))
    else $error("illegal mode switch taken");
  a_dir_lock: assert property (wrCtl && mode_r != MODE_PS2 |=> $stable(dir))
    else $error("direction changed outside mode 001");
  a_svc_set: assert property (svcCond |=> svc_r && (serviceIrq == !$past(svc_r)))
    else $error("service event not latched");
  a_svc_quiet: assert property (svc_r && !(wrEcr && !regWrData[ECR_SVC])
      |=> !serviceIrq ##1 !dmaReq || svc_r || $past(wrEcr))
    else $error("service interrupt while masked");
  a_dma_gate: assert property (!dma_transfer_enable_r || svc_r |=> !dmaReq)
    else $error("DMA request while disabled");
  a_flush_spp: assert property (mode_r == MODE_SPP |=> qEmpty)
    else $error("queue not held empty in mode 000");
  a_flag_read: assert property (regRdEn && regAddr == ADDR_ECR && !dmaAck
      |=> regRdData[ECR_FULL] == $past(qFull) && regRdData[ECR_EMPTY] == $past(qEmpty))
    else $error("full or empty flag misreported");
  a_fault_irq: assert property (mode_r == MODE_ECP && !faultDis_r && $fell(faultN)
      |=> faultIrq)
    else $error("fault edge gave no pulse");
  a_oc_ctl: assert property (mode_r == MODE_SPP |=> ctlOe == ~ctlOutN)
    else $error("control lines not open-collector in mode 000");
  a_rev_tri: assert property (revRun |=> !pdOe)
    else $error("data lines driven in reverse");
endmodule

// >>> test/ecpm_periph_model.sv
`timescale 1ns/100ps
// Far-side peripheral: takes forward bytes, offers reverse bytes on request
module ecpm_periph_model
  import ecpm_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Host lines
  input  wire logic [7:0] pdOut,
  input  wire logic [3:0] ctlOutN,
  // Reverse send request
  input  wire logic       revGo,
  input  wire logic       revData,
  input  wire logic [7:0] revByte,
  // Peripheral lines
  output logic            busyIn,
  output logic            ackInN,
  output logic      [7:0] pdIn,
  // Last forward byte, bit 8 is the host autofeed level
  output logic      [8:0] rxLast,
  output int              rxCount
);
  // Idle levels
  initial begin
    busyIn = 1'b0;
    ackInN = 1'b1;
    pdIn = 8'h00;
    rxLast = 9'h000;
    rxCount = 0;
  end
  // Forward: take byte on strobe low, answer busy after a varying delay
  always begin
    @(posedge clk);
    if (ctlOutN[0] === 1'b0) begin
      rxLast <= {ctlOutN[1], pdOut};
      rxCount <= rxCount + 1;
      repeat (1 + rxCount % 4) @(posedge clk);
      busyIn <= 1'b1;
      while (ctlOutN[0] !== 1'b1) @(posedge clk);
      busyIn <= 1'b0;
    end
  end
  // Reverse: offer a byte once the host signals ready
  always begin
    @(posedge clk);
    if (revGo) begin
      while (ctlOutN[1] !== 1'b0) @(posedge clk);
      pdIn <= revByte;
      busyIn <= revData;
      ackInN <= 1'b0;
      while (ctlOutN[1] !== 1'b1) @(posedge clk);
      ackInN <= 1'b1;
      busyIn <= 1'b0;
      pdIn <= ~revByte; // Released bus shows no stale byte
    end
  end
endmodule

// >>> test/test_ecpm_port_mode_control.sv
`timescale 1ns/100ps
module test_ecpm_port_mode_control
  import ecpm_pkg::*;
;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
  // Stimulus
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [10:0] regAddr = 11'h000;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic        dmaTc = 1'b0;
  logic        faultN = 1'b1;
  logic        revGo = 1'b0;
  logic        revData = 1'b0;
  logic [7:0]  revByte = 8'h00;
  // Observed and scratch
  logic [7:0]  regRdData, pdOut, pdIn, c, d;
  logic [3:0]  ctlOutN, ctlOe;
  logic [8:0]  rxLast;
  logic        dmaReq, faultIrq, serviceIrq, busyIn, ackInN, pdOe, eppActive;
  int          rxCount, s0, n_fail = 0, n_checks = 0, svcCnt = 0, fltCnt = 0;

  always #2 clk = ~clk;

  // Design and far side
  ecpm_port_mode_control DUT (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .dmaAck(1'b0), .dmaTc(dmaTc), .dmaReq(dmaReq), .faultIrq(faultIrq),
    .serviceIrq(serviceIrq), .faultN(faultN), .busyIn(busyIn), .ackInN(ackInN),
    .selectIn(1'b0), .paperErr(1'b0), .pdIn(pdIn), .pdOut(pdOut), .pdOe(pdOe),
    .ctlOutN(ctlOutN), .ctlOe(ctlOe), .eppActive(eppActive));
  ecpm_periph_model partner (.clk(clk), .pdOut(pdOut), .ctlOutN(ctlOutN),
    .revGo(revGo), .revData(revData), .revByte(revByte), .busyIn(busyIn),
    .ackInN(ackInN), .pdIn(pdIn), .rxLast(rxLast), .rxCount(rxCount));

  // Interrupt pulse counters
  always @(posedge clk) begin
    if (serviceIrq === 1'b1) svcCnt++;
    if (faultIrq === 1'b1) fltCnt++;
  end

  // Register write, one strobe cycle then a gap
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    @(posedge clk);
  endtask
  // Register read, data taken in the following cycle
  task automatic rdChk(input logic [10:0] a, input logic [7:0] e);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 `CHK(regRdData, e)
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Wait for the far side to count k bytes
  task automatic waitRx(input int k);
    for (int i = 0; i < 400 && rxCount < k; i++) idle(1);
  endtask
  // Far side offers one reverse byte
  task automatic revSend(input logic isData, input logic [7:0] b);
    revData <= isData;
    revByte <= b;
    revGo <= 1'b1;
    @(posedge clk);
    revGo <= 1'b0;
    for (int i = 0; i < 99 && ackInN !== 1'b0; i++) @(posedge clk);
    for (int i = 0; i < 99 && ackInN !== 1'b1; i++) @(posedge clk);
    idle(4);
  endtask
  // Service threshold crossing in test mode
  task automatic svcLevel(input logic dir, input logic [3:0] lvl);
    logic [7:0] q[$];
    int n;
    int base;
    n = dir ? 14 - lvl : 16 - lvl;
    wr(ADDR_ECR, 8'h24);
    wr(ADDR_CTRL, {2'b00, dir, 5'h00});
    wr(ADDR_LEVEL, {4'h0, lvl});
    wr(ADDR_ECR, 8'hC4);
    repeat (n) begin
      q.push_back(8'($urandom));
      wr(ADDR_FIFO, q[$]);
    end
    rdChk(ADDR_ECR, {6'b110001, n == 16, n == 0});
    base = svcCnt;
    wr(ADDR_ECR, 8'hC0);
    idle(3);
    `CHK(svcCnt, base)
    if (dir) begin
      q.push_back(8'($urandom));
      wr(ADDR_FIFO, q[$]);
    end else begin
      rdChk(ADDR_FIFO, q.pop_front());
    end
    idle(3);
    `CHK(svcCnt, base + 1)
    while (q.size() > 0) rdChk(ADDR_FIFO, q.pop_front());
    rdChk(ADDR_ECR, 8'hC5);
    `CHK(svcCnt, base + 1)
  endtask

  // Verdict
  task automatic report_and_stop;
    $display("Checks %0d, failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    void'($urandom(74));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1 `CHK(ctlOe, ~ctlOutN)
    rdChk(ADDR_ECR, 8'h05);
    rdChk(11'h7FF, 8'h00);
    wr(ADDR_CTRL, 8'h20);
    rdChk(ADDR_CTRL, 8'h00);
    wr(ADDR_ECR, 8'h24);
    wr(ADDR_CTRL, 8'h20);
    idle(2);
    `CHK({pdOe, ctlOe}, 5'h0F)
    rdChk(ADDR_ECR, 8'h25);
    wr(ADDR_ECR, 8'hE4);
    rdChk(ADDR_FIFO, CAPA_VALUE);
    wr(ADDR_ECR, 8'h24);
    wr(ADDR_LEVEL, 8'h10);
    wr(ADDR_ECR, 8'h84);
    idle(2);
    `CHK(eppActive, 1'b1)
    // Reverse ECP: command dropped, data queued
    wr(ADDR_ECR, 8'h24);
    wr(ADDR_ECR, 8'h64);
    d = 8'($urandom);
    revSend(1'b0, 8'h05);
    revSend(1'b1, d);
    rdChk(ADDR_FIFO, d);
    rdChk(ADDR_ECR, 8'h65);
    wr(ADDR_ECR, 8'h24);
    idle(3);
    `CHK(ctlOutN[1:0], 2'b11)
    // Forward ECP: command then data
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_ECR, 8'h64);
    c = 8'($urandom);
    d = 8'($urandom);
    s0 = rxCount;
    wr(ADDR_DATA, c);
    wr(ADDR_FIFO, d);
    waitRx(s0 + 1);
    `CHK(rxLast, {1'b0, c})
    waitRx(s0 + 2);
    `CHK(rxLast, {1'b1, d})
    // Fault edge and re-enable while asserted
    s0 = fltCnt;
    faultN <= 1'b0;
    idle(3);
    `CHK(fltCnt, s0 + 1)
    faultN <= 1'b1;
    wr(ADDR_ECR, 8'h74);
    faultN <= 1'b0;
    idle(3);
    `CHK(fltCnt, s0 + 1)
    wr(ADDR_ECR, 8'h64);
    idle(3);
    `CHK(fltCnt, s0 + 2)
    faultN <= 1'b1;
    wr(ADDR_ECR, 8'hC4);
    rdChk(ADDR_ECR, 8'h65);
    // Compatibility queue mode
    wr(ADDR_ECR, 8'h24);
    wr(ADDR_ECR, 8'h44);
    d = 8'($urandom);
    s0 = rxCount;
    wr(ADDR_FIFO, d);
    waitRx(s0 + 1);
    `CHK(rxLast[7:0], d)
    // DMA request and terminal count
    wr(ADDR_ECR, 8'h24);
    wr(ADDR_ECR, 8'hC4);
    wr(ADDR_ECR, 8'hCC);
    wr(ADDR_ECR, 8'hC8);
    idle(2);
    `CHK(dmaReq, 1'b1)
    s0 = svcCnt;
    dmaTc <= 1'b1;
    @(posedge clk);
    dmaTc <= 1'b0;
    idle(3);
    `CHK(svcCnt, s0 + 1)
    `CHK(dmaReq, 1'b0)
    wr(ADDR_ECR, 8'hC4);
    idle(3);
    `CHK(svcCnt, s0 + 1)
    svcLevel(1'b0, 4'h0);
    svcLevel(1'b0, 4'($urandom % 16));
    svcLevel(1'b1, 4'($urandom % 15));
    report_and_stop;
  end
endmodule
